/* design/psp_regs.svh */
// addresses, field positions, codes and reset values of the position serial port
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH
// configuration register holding coding and ring bits
`define PSP_CFG_ADDR      8'h12
`define PSP_GRAY_BIT      7
`define PSP_RING_BIT      6
`define PSP_CFG_RST       2'h0
// port a interface mode codes
`define PSP_MODE_SPI_TRI  3'h0
`define PSP_MODE_SPI      3'h1
`define PSP_MODE_SSI      3'h4
`define PSP_MODE_SSI_ERRL 3'h5
`define PSP_MODE_SSI_ERRH 3'h6
`define PSP_MODE_SSI_EXT  3'h7
// opcode bytes
`define PSP_OP_ACTIVATE   8'hb0
`define PSP_OP_SENS_XFER  8'ha6
`define PSP_OP_SENS_STAT  8'hf5
`define PSP_OP_REG_READ   8'h97
`define PSP_OP_REG_WRITE  8'hd2
`define PSP_OP_REG_STAT   8'had
// status byte: error 7, reserved 6..4, rejected 3, failed 2, busy 1, valid 0
`define PSP_REG_EN_RST    1'h1
`define PSP_SENS_EN_RST   1'h1
// crc x^6+x^1+x^0, top term implied
`define PSP_CRC_POLY      6'h03
// pin slots in the synchroniser and their idle levels (cs high, ma high)
`define PSP_PIN_CS        0
`define PSP_PIN_SCLK      1
`define PSP_PIN_MOSI      2
`define PSP_PIN_MA        3
`define PSP_PIN_IDLE      4'h9
`endif

/* design/psp_pkg.sv */
// types shared by the position serial port modules
package psp_pkg;
  // spi transaction phase, one-hot
  typedef enum logic [3:0] {
    PSP_OPC   = 4'h1,
    PSP_ECHO  = 4'h2,
    PSP_CHAIN = 4'h4,
    PSP_SHIFT = 4'h8
  } psp_phase_type;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
  } psp_sync_type;

  typedef struct packed {
    psp_phase_type ph;
    logic [2:0]  bitc;
    logic [7:0]  byt;
    logic [1:0]  bcnt;
    logic [7:0]  cmd;
    logic [1:0]  ch;
    logic        clen;
    logic [39:0] sh;
    logic [2:0]  win;
    logic        got;
    logic        ign;
    logic [39:0] spos;
    logic        sok;
    logic        err;
    logic        rej;
    logic        fail;
    logic        busy;
    logic        valid;
    logic [7:0]  rdat;
    logic [7:0]  addr;
    logic [7:0]  wdat;
    logic        rd_stb;
    logic        wr_stb;
    logic        reg_en;
    logic        sens_en;
    logic        gray;
    logic        ring;
    logic        miso;
    logic        oe;
    logic        s_on;
    logic        s_first;
    logic [11:0] tcnt;
    logic [11:0] tout;
    logic [47:0] fr;
    logic [5:0]  flen;
    logic [5:0]  idx;
  } psp_state_type;
endpackage

/* design/psp_pin_if.sv */
// synchronised pin levels and edges passed to the port logic
`timescale 1ns/1ps
`default_nettype none
interface psp_pin_if;
  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface // psp_pin_if
`default_nettype wire

/* design/psp_pin_sync.sv */
// two-stage synchroniser and edge finder for the serial pins
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"
module psp_pin_sync (
  input  wire logic   core_clk,
  input  wire logic   rst,
  input  wire logic [3:0] pin_raw,
  psp_pin_if.src      pins
);
  psp_pkg::psp_sync_type q;
  psp_pkg::psp_sync_type d;

  // s1 feeds only s2; edges compare s2 against s3
  always_comb begin
    d    = q;
    d.s1 = pin_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q.s1 <= `PSP_PIN_IDLE;
      q.s2 <= `PSP_PIN_IDLE;
      q.s3 <= `PSP_PIN_IDLE;
    end else begin
      q <= d;
    end
  end

  // levels and one-cycle edge pulses
  assign pins.lvl  = q.s2;
  assign pins.rise = q.s2 & ~q.s3;
  assign pins.fall = ~q.s2 & q.s3;
endmodule // psp_pin_sync
`default_nettype wire

/* design/psp_port.sv */
// spi slave and ssi sensor-data port of the position encoder
//
// How it works
// [RQ1] ssi mode code picks frame: 4 plain, 5 low error, 6 high error, 7 extended.
// [RQ2] standard ssi frame: position, optional error bit, then a stop zero.
// [RQ3] extended frame: position, error, warning, crc; msb first.
// [RQ4] ssi end-of-frame timeout scales with the first measured clock half period.
// [RQ5] coding bit selects binary or gray ssi position.
// [RQ6] ring on repeats the word after one zero; off sends zeros.
// [RQ7] spi mode 0 floats the line when deselected, mode 1 drives it high.
// [RQ8] spi mode 0 and 3 both work; data sampled on rising clock.
// [RQ9] bytes of eight bits, msb first, opcode first.
// [RQ10] chip select frames a transaction; input echoed to output meanwhile.
// [RQ11] six opcodes decoded: activate, sensor transfer, sensor poll, read, write, status.
// [RQ12] master keeps sensor word a whole number of bytes.
// [RQ13] activate places both enables in the chain, cleared, then reloads them.
// [RQ14] both channel enables are one after startup.
// [RQ15] activate clears failed, valid, busy and rejected flags.
// [RQ16] disabled channel: command skipped, error set, input echoed.
// [RQ17] single slave sends the two enables in the last byte bits.
// [RQ18] position latched on the first rising clock while selected.
// [RQ19] sensor transfer shifts 8 to 40 bits through the chain.
// [RQ20] invalid latched data sets error and sends zero bytes.
// [RQ21] sensor poll places the valid bit in the chain; next latch skipped.
// [RQ22] valid bit is one when data valid; single slave bit 7.
// [RQ23] status byte: error 7, rejected 3, failed 2, busy 1, valid 0.
// [RQ24] status opcode returns status byte then one data byte.
// [RQ25] gray code is reflected binary over the whole position word.
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"
module psp_port #(
  parameter logic [7:0] ADDR_TOP = 8'h7f
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  port_a_interface_mode,
  input  wire logic        chip_select_n,
  input  wire logic        spi_clock,
  input  wire logic        spi_data_in,
  input  wire logic        ssi_master_clock,
  input  wire logic [39:0] pos_word,
  input  wire logic [5:0]  pos_bits,
  input  wire logic [2:0]  sens_bytes,
  input  wire logic        pos_valid,
  input  wire logic        pos_warning,
  input  wire logic [7:0]  reg_rdata,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_rd_stb,
  output logic             reg_wr_stb,
  output logic             gray_code_select,
  output logic             ring_output_enable,
  output logic             register_channel_enable,
  output logic             sensor_channel_enable,
  output logic             sensor_valid_flag,
  output logic [7:0]       spi_status
);
  psp_pkg::psp_state_type q;
  psp_pkg::psp_state_type n;
  psp_pin_if pins ();

  // ****************************************
  // pin synchronisation
  // ****************************************
  psp_pin_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_raw  ({ssi_master_clock, spi_data_in, spi_clock, chip_select_n}),
    .pins     (pins)
  );

  logic        spi_on;
  logic        ssi_on;
  logic        cs_lo;
  logic        sck_rise;
  logic        mosi;
  logic        ma_rise;
  logic        ma_fall;
  logic [7:0]  op;
  logic [7:0]  stat;
  logic [5:0]  sens_sh;
  logic [5:0]  win_idx;
  logic [39:0] sens_img;
  logic [39:0] pos_code;
  logic [47:0] code_al;
  logic [47:0] tail_al;
  logic [5:0]  crc;
  logic [47:0] frame_w;
  logic [5:0]  frame_len;

  // only the rising spi clock is used, so idle level 0 or 1 both work
  assign spi_on   = port_a_interface_mode[2:1] == 2'h0;
  assign ssi_on   = port_a_interface_mode[2];
  assign cs_lo    = !pins.lvl[`PSP_PIN_CS];
  assign sck_rise = pins.rise[`PSP_PIN_SCLK]; // RQ8
  assign mosi     = pins.lvl[`PSP_PIN_MOSI];
  assign ma_rise  = pins.rise[`PSP_PIN_MA];
  assign ma_fall  = pins.fall[`PSP_PIN_MA];
  assign op       = {q.byt[6:0], mosi}; // RQ9

  // status byte, reserved bits read zero
  assign stat = {q.err, 3'h0, q.rej, q.fail, q.busy, q.valid}; // RQ23

  // ****************************************
  // frame images
  // ****************************************
  // sensor word left aligned; whole-byte length is the master's job
  assign sens_sh  = 6'h28 - {sens_bytes, 3'h0}; // RQ12
  assign sens_img = q.sok ? (q.spos << sens_sh) : 40'h0; // RQ20
  assign win_idx  = 6'h28 - {q.win, 3'h0};

  // reflected gray over the whole word; upper zeros keep it exact
  assign pos_code = q.gray ? (pos_word ^ (pos_word >> 1)) : pos_word; // RQ5 RQ25
  assign code_al  = {pos_code, 8'h00} << (6'h28 - pos_bits);
  assign tail_al  = {pos_valid, !pos_warning, 46'h0} >> pos_bits;

  function automatic logic [5:0] psp_crc6(input logic [47:0] dat, input logic [5:0] len);
    logic [5:0] c;
    logic       fb;
    c  = 6'h00;
    fb = 1'h0;
    for (int i = 0; i < 48; i++) begin
      fb = c[5] ^ dat[47 - i];
      if (i < int'(len)) c = {c[4:0], 1'h0} ^ (fb ? `PSP_CRC_POLY : 6'h00);
    end
    return c;
  endfunction

  assign crc = psp_crc6(code_al | tail_al, pos_bits + 6'h02);

  // frame per mode; the stop zero is sent once idx reaches flen
  always_comb begin
    frame_w   = code_al;
    frame_len = pos_bits; // RQ2
    case (port_a_interface_mode)
      `PSP_MODE_SSI_ERRL: begin
        frame_w   = code_al | ({pos_valid, 47'h0} >> pos_bits); // RQ1
        frame_len = pos_bits + 6'h01;
      end
      `PSP_MODE_SSI_ERRH: begin
        frame_w   = code_al | ({!pos_valid, 47'h0} >> pos_bits); // RQ1
        frame_len = pos_bits + 6'h01;
      end
      `PSP_MODE_SSI_EXT: begin
        // crc sent inverted, all fields msb first
        frame_w   = code_al | tail_al | ({~crc, 42'h0} >> (pos_bits + 6'h02)); // RQ3
        frame_len = pos_bits + 6'h08;
      end
      default: begin
        frame_w   = code_al; // RQ1
        frame_len = pos_bits;
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n        = q;
    n.rd_stb = 1'h0;
    n.wr_stb = 1'h0;
    // read answer one cycle after the strobe
    if (q.rd_stb) begin
      n.rdat  = (q.addr == `PSP_CFG_ADDR) ? {q.gray, q.ring, reg_rdata[5:0]} : reg_rdata;
      n.busy  = 1'h0;
      n.valid = 1'h1;
    end
    if (!spi_on || !cs_lo) begin
      // deselected: close transaction, idle line per mode
      if (q.ph == psp_pkg::PSP_CHAIN && q.clen) begin
        n.reg_en  = q.ch[1]; // RQ13
        n.sens_en = q.ch[0];
      end
      n.ph   = psp_pkg::PSP_OPC;
      n.bitc = 3'h0;
      n.bcnt = 2'h0;
      n.got  = 1'h0;
      n.miso = 1'h1;
      n.oe   = port_a_interface_mode == `PSP_MODE_SPI; // RQ7
    end else begin
      n.oe = 1'h1;
      // echo input level straight through
      if (q.ph == psp_pkg::PSP_OPC || q.ph == psp_pkg::PSP_ECHO) n.miso = mosi; // RQ10
      if (sck_rise) begin
        n.bitc = q.bitc + 3'h1;
        n.byt  = op;
        // first edge of the transaction latches, unless a poll asked to skip
        if (!q.got) begin
          n.got = 1'h1;
          if (q.ign) begin
            n.ign = 1'h0; // RQ21
          end else begin
            n.spos = pos_word; // RQ18
            n.sok  = pos_valid;
          end
        end
        case (q.ph)
          psp_pkg::PSP_OPC: begin
            if (q.bitc == 3'h7) begin
              n.cmd = op;
              case (op) // RQ11
                `PSP_OP_ACTIVATE: begin
                  n.ph    = psp_pkg::PSP_CHAIN; // RQ13
                  n.clen  = 1'h1;
                  n.ch    = 2'h0;
                  n.miso  = 1'h0;
                  n.fail  = 1'h0; // RQ15
                  n.valid = 1'h0;
                  n.busy  = 1'h0;
                  n.rej   = 1'h0;
                  n.err   = 1'h0;
                end
                `PSP_OP_SENS_XFER: begin
                  if (!q.sens_en) begin
                    n.ph  = psp_pkg::PSP_ECHO; // RQ16
                    n.err = 1'h1;
                  end else begin
                    n.ph   = psp_pkg::PSP_SHIFT; // RQ19
                    n.win  = sens_bytes;
                    n.sh   = sens_img;
                    n.miso = sens_img[39];
                    n.err  = !q.sok; // RQ20
                  end
                end
                `PSP_OP_SENS_STAT: begin
                  if (!q.sens_en) begin
                    n.ph  = psp_pkg::PSP_ECHO; // RQ16
                    n.err = 1'h1;
                  end else begin
                    // valid bit leads, so a lone slave shows it at bit 7
                    n.ph    = psp_pkg::PSP_CHAIN; // RQ21
                    n.clen  = 1'h0;
                    n.ch[0] = pos_valid; // RQ22
                    n.miso  = pos_valid;
                    n.ign   = 1'h1;
                    n.err   = 1'h0;
                  end
                end
                `PSP_OP_REG_READ, `PSP_OP_REG_WRITE: begin
                  n.ph  = psp_pkg::PSP_ECHO;
                  n.err = !q.reg_en; // RQ16
                end
                `PSP_OP_REG_STAT: begin
                  if (!q.reg_en) begin
                    n.ph  = psp_pkg::PSP_ECHO; // RQ16
                    n.err = 1'h1;
                  end else begin
                    n.ph   = psp_pkg::PSP_SHIFT; // RQ24
                    n.win  = 3'h2;
                    n.sh   = {stat, q.rdat, 24'h0};
                    n.miso = stat[7];
                  end
                end
                default: begin
                  n.ph  = psp_pkg::PSP_ECHO;
                  n.err = 1'h1;
                end
              endcase
            end
          end
          psp_pkg::PSP_ECHO: begin
            // address and data bytes of an enabled register access
            if (q.bitc == 3'h7 && q.reg_en && q.bcnt != 2'h3) begin
              n.bcnt = q.bcnt + 2'h1;
              if (q.cmd == `PSP_OP_REG_READ && q.bcnt == 2'h0) begin
                n.addr  = op;
                n.rej   = op > ADDR_TOP;
                n.fail  = op > ADDR_TOP;
                n.valid = 1'h0;
                n.busy  = op <= ADDR_TOP;
                n.rd_stb = op <= ADDR_TOP;
              end
              if (q.cmd == `PSP_OP_REG_WRITE && q.bcnt == 2'h0) begin
                n.addr  = op;
                n.valid = 1'h0;
              end
              if (q.cmd == `PSP_OP_REG_WRITE && q.bcnt == 2'h1) begin
                n.rej   = q.addr > ADDR_TOP;
                n.fail  = q.addr > ADDR_TOP;
                n.valid = q.addr <= ADDR_TOP;
                n.wdat  = op;
                n.rdat  = op;
                n.wr_stb = q.addr <= ADDR_TOP;
                if (q.addr == `PSP_CFG_ADDR) begin
                  n.gray = op[`PSP_GRAY_BIT]; // RQ5
                  n.ring = op[`PSP_RING_BIT]; // RQ6
                end
              end
            end
          end
          psp_pkg::PSP_CHAIN: begin
            // enables sit in the data path; the last bits to pass stay
            if (q.clen) begin
              n.ch   = {q.ch[0], mosi}; // RQ17
              n.miso = q.ch[0];
            end else begin
              n.ch[0] = mosi;
              n.miso  = mosi;
            end
          end
          psp_pkg::PSP_SHIFT: begin
            // window of win bytes; input enters at its lowest bit, win_idx, for the chain
            n.sh          = {q.sh[38:0], 1'h0}; // RQ19
            n.sh[win_idx] = mosi;
            n.miso        = q.sh[38];
          end
          default: n.ph = psp_pkg::PSP_OPC;
        endcase
      end
    end

    // ssi engine shares the output line
    if (!ssi_on) begin
      n.s_on = 1'h0;
    end else begin
      n.oe = 1'h1;
      n.tcnt = (&q.tcnt) ? q.tcnt : q.tcnt + 12'h001;
      if (ma_rise || ma_fall) n.tcnt = 12'h000;
      if (!q.s_on) begin
        n.miso = 1'h1;
        if (ma_fall) begin
          n.s_on    = 1'h1;
          n.s_first = 1'h1;
          n.fr      = frame_w;
          n.flen    = frame_len;
          n.idx     = 6'h00;
        end
      end else begin
        // the bit must stand until the next rise, not fall back to idle
        n.miso = q.miso;
        if (ma_rise) begin
          // first half period sets the timeout scale
          if (q.s_first) begin
            n.tout    = q.tcnt; // RQ4
            n.s_first = 1'h0;
          end
          if (q.idx == q.flen) begin
            n.miso = 1'h0; // RQ6
            n.idx  = q.ring ? 6'h00 : q.flen;
          end else begin
            n.miso = q.fr[6'h2f - q.idx];
            n.idx  = q.idx + 6'h01;
          end
        end
        // clock idle high beyond twice the first half period ends the frame
        if (!q.s_first && pins.lvl[`PSP_PIN_MA] && q.tcnt > {q.tout[10:0], 1'h0}) begin
          n.s_on = 1'h0; // RQ4
          n.miso = 1'h1;
        end
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.ph      <= psp_pkg::PSP_OPC;
      q.reg_en  <= `PSP_REG_EN_RST; // RQ14
      q.sens_en <= `PSP_SENS_EN_RST;
      q.miso    <= 1'h1;
    end else begin
      q <= n;
    end
  end

  // all outputs straight from state flops
  assign serial_data_out         = q.miso;
  assign serial_data_oe          = q.oe;
  assign reg_addr                = q.addr;
  assign reg_wdata               = q.wdat;
  assign reg_rd_stb              = q.rd_stb;
  assign reg_wr_stb              = q.wr_stb;
  assign gray_code_select        = q.gray;
  assign ring_output_enable      = q.ring;
  assign register_channel_enable = q.reg_en;
  assign sensor_channel_enable   = q.sens_en;
  assign sensor_valid_flag       = q.sok;
  assign spi_status              = stat;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic dec_q;
  assign dec_q = spi_on && cs_lo && sck_rise && q.ph == psp_pkg::PSP_OPC && q.bitc == 3'h7;

  a_tri_idle: assert property ( // RQ7
    (port_a_interface_mode == `PSP_MODE_SPI_TRI && !cs_lo) |=> !serial_data_oe)
    else $error("line driven while deselected in tristate mode");
  a_high_idle: assert property ( // RQ7
    (port_a_interface_mode == `PSP_MODE_SPI && !cs_lo) |=> serial_data_oe && serial_data_out)
    else $error("line not high while deselected");
  a_echo_line: assert property ( // RQ10
    (spi_on && cs_lo && q.ph == psp_pkg::PSP_ECHO && !sck_rise) |=> serial_data_out == $past(mosi))
    else $error("input not echoed");
  a_act_clear: assert property ( // RQ13
    (dec_q && op == `PSP_OP_ACTIVATE) |=> q.ph == psp_pkg::PSP_CHAIN && q.ch == 2'h0)
    else $error("activate did not clear enables");
  a_act_flags: assert property ( // RQ15
    (dec_q && op == `PSP_OP_ACTIVATE) |=> spi_status[3:0] == 4'h0)
    else $error("activate left status flags set");
  a_en_startup: assert property ( // RQ14
    $fell(rst) |-> register_channel_enable && sensor_channel_enable)
    else $error("enables not set after startup");
  a_reg_refused: assert property ( // RQ16
    (dec_q && !q.reg_en && op == `PSP_OP_REG_STAT) |=> q.err && q.ph == psp_pkg::PSP_ECHO)
    else $error("disabled register command not refused");
  a_latch_first: assert property ( // RQ18
    (spi_on && cs_lo && sck_rise && !q.got && !q.ign) |=> q.spos == $past(pos_word) && q.got)
    else $error("position not latched on first edge");
  a_bad_zero: assert property ( // RQ20
    (dec_q && op == `PSP_OP_SENS_XFER && q.sens_en && !q.sok) |=> q.sh == 40'h0 && q.err)
    else $error("invalid sensor data not zeroed");
  a_poll_bit: assert property ( // RQ21
    (dec_q && op == `PSP_OP_SENS_STAT && q.sens_en) |=> serial_data_out == $past(pos_valid) ##0 q.ign)
    else $error("valid bit not placed or skip not armed");

  c_activate: cover property (dec_q && op == `PSP_OP_ACTIVATE);
  c_sens_xfer: cover property (dec_q && op == `PSP_OP_SENS_XFER && q.sens_en);
  c_ssi_frame: cover property (ssi_on && !q.s_on ##1 q.s_on);
  c_ssi_ring: cover property (q.s_on && q.ring && ma_rise && q.idx == q.flen);
endmodule // psp_port
`default_nettype wire

/* test/psp_master.sv */
// bus master model driving the spi and ssi pins of the position serial port
`timescale 1ns/1ps
`default_nettype none
module psp_master (
  input  wire logic clk,
  input  wire logic miso,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic mosi,
  output var  logic ma
);
  // ****************************************
  // pin sequencing
  // ****************************************
  logic cpol;

  // idle: deselected, clock at its idle level, ma high
  initial begin
    cpol = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    ma   = 1'b1;
  end

  // half a link period, 8 core cycles, moved just after an edge
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // msb first; mosi moves while sclk is low, miso taken just before the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      half();
      rx[i] = miso;
      sclk = 1'b1;
      half();
    end
  endtask

  task automatic open();
    sclk = cpol;
    half();
    cs_n = 1'b0;
    half();
  endtask

  // mosi flips on release so the port cannot lean on a held level
  task automatic close();
    half();
    sclk = cpol;
    half();
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (4) half();
  endtask

  // ssi read of n bits, then ma idles high past the adaptive timeout
  task automatic ssi(input int n, output logic [47:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      ma = 1'b0;
      half();
      ma = 1'b1;
      half();
      rx[i] = miso;
    end
    repeat (6) half();
  endtask
endmodule // psp_master
`default_nettype wire

/* test/testbench.sv */
// self-checking testbench of the position serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************
  // stimulus, models and checks
  // ****************************************
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic [2:0]  mode     = 3'h1;
  logic [39:0] pos      = 40'h12_3456;
  logic [5:0]  pbits    = 6'h08;
  logic [2:0]  sbytes   = 3'h2;
  logic        valid    = 1'b1;
  logic [7:0]  rdata    = 8'h5a;
  wire logic   cs_n, sclk, mosi, ma, out, oe, rd, wr, gray, ring, ren, sen, sv;
  wire logic [7:0] addr, wdata, status;
  wire logic   miso = oe ? out : core_clk; // released line toggles
  int          num_errors = 0;
  int          n_checks   = 0;
  int          n_rd       = 0;
  int          n_wr       = 0;
  logic [7:0]  last_addr, last_wdata;
  logic [23:0] rx;
  logic [47:0] srx;
  logic [7:0]  g;

  always #5 core_clk = ~core_clk;

  psp_port i_psp_port (.core_clk(core_clk), .rst(rst), .port_a_interface_mode(mode),
    .chip_select_n(cs_n), .spi_clock(sclk), .spi_data_in(mosi), .ssi_master_clock(ma),
    .pos_word(pos), .pos_bits(pbits), .sens_bytes(sbytes), .pos_valid(valid),
    .pos_warning(1'b0), .reg_rdata(rdata), .serial_data_out(out), .serial_data_oe(oe),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rd_stb(rd), .reg_wr_stb(wr),
    .gray_code_select(gray), .ring_output_enable(ring), .register_channel_enable(ren),
    .sensor_channel_enable(sen), .sensor_valid_flag(sv), .spi_status(status));
  psp_master i_psp_master (.clk(core_clk), .miso(miso), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .ma(ma));

  // strobes are one cycle wide, so count them here rather than poll
  always @(posedge core_clk) begin
    if (wr === 1'b1) n_wr++;
    if (wr === 1'b1) last_wdata <= wdata;
    if (rd === 1'b1) n_rd++;
    if ((rd | wr) === 1'b1) last_addr <= addr;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // opcode then nb argument bytes; everything seen on miso lands in rx
  task automatic spi(input logic [7:0] op, input logic [15:0] arg, input int nb);
    logic [7:0] b;
    rx = '0;
    i_psp_master.open();
    i_psp_master.xfer(op, b);
    rx[23:16] = b;
    for (int k = 0; k < nb; k++) begin
      i_psp_master.xfer(arg[15 - 8 * k -: 8], b);
      rx[15 - 8 * k -: 8] = b;
    end
    i_psp_master.close();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hang costs far less than this; the whole run needs about 6.4k cycles
  initial begin
    #500000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    i_psp_master.half();
    check("reset", {ren, sen, gray, ring, status, oe, out}, {4'hc, 8'h00, 2'h3});
    mode = 3'h0;
    i_psp_master.half();
    check("float", oe, 1'b0);
    spi(8'hd2, 16'h12c0, 2);
    check("write echo", rx, 24'hd212c0);
    check("write", {n_wr[7:0], last_addr, last_wdata, gray, ring}, {8'h01, 8'h12, 8'hc0, 2'h3});
    spi(8'had, 16'h0000, 2);
    check("write status", rx[15:0], 16'h01c0);
    i_psp_master.cpol = 1'b1;
    spi(8'h97, 16'h0500, 1);
    spi(8'had, 16'h0000, 2);
    check("read status", {n_rd[7:0], last_addr, rx[15:0]}, {8'h01, 8'h05, 16'h015a});
    spi(8'h97, 16'h8000, 1);
    check("reject", {n_rd[7:0], 4'h0, status[3:2]}, {8'h01, 4'h0, 2'h3});
    i_psp_master.cpol = 1'b0;
    $display("test registers done");
    spi(8'hb0, 16'h0000, 1);
    check("activate", {ren, sen, status[3:0]}, 6'h00);
    spi(8'hf5, 16'h3c00, 1);
    check("disabled", {status[7], rx[23:8]}, 17'h1f53c);
    spi(8'had, 16'h1234, 2);
    check("reg refused", {status[7], rx}, {1'b1, 24'had1234});
    spi(8'hb0, 16'h0300, 1);
    check("enable", {ren, sen, status[7]}, 3'h6);
    spi(8'ha6, 16'h0000, 2);
    check("sensor", {status[7], rx}, 25'h0a63456);
    valid = 1'b0;
    spi(8'ha6, 16'h0000, 2);
    check("invalid", {status[7], sv, rx[15:0]}, 18'h20000);
    valid = 1'b1;
    spi(8'hf5, 16'h0000, 1);
    check("poll", rx[15], 1'b1);
    pos = 40'habcd;
    spi(8'ha6, 16'h0000, 2);
    check("latch skipped", rx[15:0], 16'h3456);
    $display("test sensor done");
    pos = 40'ha5;
    g = 8'ha5 ^ 8'h52;
    for (int m = 4; m <= 7; m++) begin
      mode = m[2:0];
      i_psp_master.half();
      i_psp_master.ssi(17, srx);
      if (m == 4) check("ssi ring", srx[16:0], {g, 1'b0, g});
      else if (m == 7) check("ssi ext", srx[16:0], {g, 2'h3, 6'h2d, 1'b0});
      else check("ssi frame", srx[16:8], {g, m == 5});
    end
    $display("test ssi done");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
